// *** hw/ipfb_pkg.sv ***
// Package with register map, field layout and reset values of the priority bank
package ipfb_pkg;
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned LVL_W = 3;
  // Register offsets
  localparam logic [3:0] OFF_BANK_FIVE = 4'h0;
  localparam logic [3:0] OFF_BANK_SEVEN = 4'h2;
  localparam logic [3:0] OFF_BANK_EIGHT = 4'h3;
  localparam logic [3:0] OFF_BANK_NINE = 4'h4;
  // Writable bit masks
  localparam logic [15:0] MASK_BANK_FIVE = 16'h7770;
  localparam logic [15:0] MASK_BANK_SEVEN = 16'h7777;
  localparam logic [15:0] MASK_BANK_EIGHT = 16'h0077;
  localparam logic [15:0] MASK_BANK_NINE = 16'h7770;
  // Reset values: each field resets to level 4
  localparam logic [15:0] RST_BANK_FIVE = 16'h4440;
  localparam logic [15:0] RST_BANK_SEVEN = 16'h4444;
  localparam logic [15:0] RST_BANK_EIGHT = 16'h0044;
  localparam logic [15:0] RST_BANK_NINE = 16'h4440;
  // Field low bit positions
  localparam int unsigned POS_HI = 12;
  localparam int unsigned POS_MH = 8;
  localparam int unsigned POS_ML = 4;
  localparam int unsigned POS_LO = 0;
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage

// *** hw/ipfb_sync.sv ***
// Reset release synchroniser
`timescale 1ns/1ps
module ipfb_sync (
  // Clock and raw reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised reset
  output logic rst_sync_n
);
  logic s1_q;
  logic s2_q;
  // Two flops release the reset cleanly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= 1'b1;
      s2_q <= s1_q;
    end
  end
  assign rst_sync_n = s2_q;
endmodule

// *** hw/ipfb_preg.sv ***
// One priority register with a mask of implemented bits
`timescale 1ns/1ps
module ipfb_preg #(
  parameter logic [15:0] MASK = 16'hffff,
  parameter logic [15:0] RSTV = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // Stored value
  output logic [15:0] value
);
  logic [15:0] val_q;
  logic [15:0] val_d;
  // Only implemented bits take write data
  always_comb begin
    val_d = val_q;
    if (wr_en) begin
      val_d = wr_data & MASK;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_q <= RSTV & MASK;
    end else begin
      val_q <= val_d;
    end
  end
  assign value = val_q;
endmodule

// *** hw/ipfb_top.sv ***
// Interrupt priority field bank: four registers and per-source level outputs
`timescale 1ns/1ps
module ipfb_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Levels, timer and compare
  output logic [2:0] timer_four_level,
  output logic [2:0] compare_ch4_level,
  output logic [2:0] compare_ch3_level,
  output logic [2:0] timer_five_level,
  // Levels, uart and external
  output logic [2:0] uart_b_transmit_level,
  output logic [2:0] uart_b_receive_level,
  output logic [2:0] ext_irq_two_level,
  // Levels, spi
  output logic [2:0] spi_b_event_level,
  output logic [2:0] spi_b_fault_level,
  // Levels, capture
  output logic [2:0] capture_ch5_level,
  output logic [2:0] capture_ch4_level,
  output logic [2:0] capture_ch3_level,
  // Source enables, high when level is not zero
  output logic [11:0] src_enable
);
  logic rst_s_n;
  logic [15:0] b5;
  logic [15:0] b7;
  logic [15:0] b8;
  logic [15:0] b9;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [35:0] lvl_q;
  logic [35:0] lvl_d;
  logic [11:0] en_q;
  logic [11:0] en_d;

  ipfb_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .rst_sync_n(rst_s_n)
  );

  // Four priority registers, each with its own implemented-bit mask
  ipfb_preg #(.MASK(ipfb_pkg::MASK_BANK_FIVE), .RSTV(ipfb_pkg::RST_BANK_FIVE)) u_b5 (
    .clk(clk),
    .rst_n(rst_s_n),
    .wr_en(wr && addr == ipfb_pkg::OFF_BANK_FIVE),
    .wr_data(wdata),
    .value(b5)
  );
  ipfb_preg #(.MASK(ipfb_pkg::MASK_BANK_SEVEN), .RSTV(ipfb_pkg::RST_BANK_SEVEN)) u_b7 (
    .clk(clk),
    .rst_n(rst_s_n),
    .wr_en(wr && addr == ipfb_pkg::OFF_BANK_SEVEN),
    .wr_data(wdata),
    .value(b7)
  );
  ipfb_preg #(.MASK(ipfb_pkg::MASK_BANK_EIGHT), .RSTV(ipfb_pkg::RST_BANK_EIGHT)) u_b8 (
    .clk(clk),
    .rst_n(rst_s_n),
    .wr_en(wr && addr == ipfb_pkg::OFF_BANK_EIGHT),
    .wr_data(wdata),
    .value(b8)
  );
  ipfb_preg #(.MASK(ipfb_pkg::MASK_BANK_NINE), .RSTV(ipfb_pkg::RST_BANK_NINE)) u_b9 (
    .clk(clk),
    .rst_n(rst_s_n),
    .wr_en(wr && addr == ipfb_pkg::OFF_BANK_NINE),
    .wr_data(wdata),
    .value(b9)
  );

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = ipfb_pkg::ZERO16;
    if (rd) begin
      unique case (addr)
        ipfb_pkg::OFF_BANK_FIVE: rdata_d = b5;
        ipfb_pkg::OFF_BANK_SEVEN: rdata_d = b7;
        ipfb_pkg::OFF_BANK_EIGHT: rdata_d = b8;
        ipfb_pkg::OFF_BANK_NINE: rdata_d = b9;
        default: rdata_d = ipfb_pkg::ZERO16;
      endcase
    end
  end

  // Field extraction into a flat level vector, one cycle after storage
  always_comb begin
    lvl_d[2:0] = b5[ipfb_pkg::POS_HI +: ipfb_pkg::LVL_W];
    lvl_d[5:3] = b5[ipfb_pkg::POS_MH +: ipfb_pkg::LVL_W];
    lvl_d[8:6] = b5[ipfb_pkg::POS_ML +: ipfb_pkg::LVL_W];
    lvl_d[11:9] = b7[ipfb_pkg::POS_HI +: ipfb_pkg::LVL_W];
    lvl_d[14:12] = b7[ipfb_pkg::POS_MH +: ipfb_pkg::LVL_W];
    lvl_d[17:15] = b7[ipfb_pkg::POS_ML +: ipfb_pkg::LVL_W];
    lvl_d[20:18] = b7[ipfb_pkg::POS_LO +: ipfb_pkg::LVL_W];
    lvl_d[23:21] = b8[ipfb_pkg::POS_ML +: ipfb_pkg::LVL_W];
    lvl_d[26:24] = b8[ipfb_pkg::POS_LO +: ipfb_pkg::LVL_W];
    lvl_d[29:27] = b9[ipfb_pkg::POS_HI +: ipfb_pkg::LVL_W];
    lvl_d[32:30] = b9[ipfb_pkg::POS_MH +: ipfb_pkg::LVL_W];
    lvl_d[35:33] = b9[ipfb_pkg::POS_ML +: ipfb_pkg::LVL_W];
    // Level code passes straight through: 7 highest, 1 lowest, 0 off
    for (int i = 0; i < 12; i++) begin
      en_d[i] = lvl_d[i*3 +: 3] != ipfb_pkg::LVL_OFF;
    end
  end

  // Output registers
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rdata_q <= 16'h0000;
      lvl_q <= 36'h0;
      en_q <= 12'h000;
    end else begin
      rdata_q <= rdata_d;
      lvl_q <= lvl_d;
      en_q <= en_d;
    end
  end

  // Output mapping
  assign rdata = rdata_q;
  assign timer_four_level = lvl_q[2:0];
  assign compare_ch4_level = lvl_q[5:3];
  assign compare_ch3_level = lvl_q[8:6];
  assign uart_b_transmit_level = lvl_q[11:9];
  assign uart_b_receive_level = lvl_q[14:12];
  assign ext_irq_two_level = lvl_q[17:15];
  assign timer_five_level = lvl_q[20:18];
  assign spi_b_event_level = lvl_q[23:21];
  assign spi_b_fault_level = lvl_q[26:24];
  assign capture_ch5_level = lvl_q[29:27];
  assign capture_ch4_level = lvl_q[32:30];
  assign capture_ch3_level = lvl_q[35:33];
  assign src_enable = en_q;
endmodule

// *** verification/ipfb_top_sva.sv ***
// Assertion checker for the interrupt priority field bank
`timescale 1ns/1ps
module ipfb_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // Watched levels and enables
  input wire logic [2:0] timer_four_level,
  input wire logic [2:0] uart_b_transmit_level,
  input wire logic [2:0] spi_b_fault_level,
  input wire logic [2:0] capture_ch3_level,
  input wire logic [11:0] src_enable
);
  // One clock domain, raw reset disables all checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  idle_read_zero_a: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("rdata not zero outside a read");
  gap_bits_zero_a: assert property ((rdata & 16'h8888) == 16'h0000)
    else $error("unassigned bit read as one");
  bank_eight_top_a: assert property (rd && addr == 4'h3 |=> rdata[15:8] == 8'h00)
    else $error("bank eight upper byte not zero");
  low_nibble_zero_a: assert property (rd && (addr == 4'h0 || addr == 4'h4) |=>
    rdata[3:0] == 4'h0) else $error("low nibble not zero");
  timer_four_a: assert property (wr && addr == 4'h0 |-> ##2
    timer_four_level == $past(wdata[14:12], 2)) else $error("timer four level wrong");
  uart_tx_a: assert property (wr && addr == 4'h2 |-> ##2
    uart_b_transmit_level == $past(wdata[14:12], 2)) else $error("uart tx level wrong");
  spi_fault_a: assert property (wr && addr == 4'h3 |-> ##2
    spi_b_fault_level == $past(wdata[2:0], 2)) else $error("spi fault level wrong");
  capture_three_a: assert property (wr && addr == 4'h4 |-> ##2
    capture_ch3_level == $past(wdata[6:4], 2)) else $error("capture three level wrong");
  source_enable_a: assert property (src_enable[0] == (|timer_four_level) &&
    src_enable[11] == (|capture_ch3_level)) else $error("source enable mismatch");
endmodule
bind ipfb_top ipfb_top_sva u_ipfb_top_sva (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_four_level(timer_four_level),
  .uart_b_transmit_level(uart_b_transmit_level), .spi_b_fault_level(spi_b_fault_level),
  .capture_ch3_level(capture_ch3_level), .src_enable(src_enable));

// *** verification/test_ipfb_top.sv ***
// Self-checking bench for the interrupt priority field bank
`timescale 1ns/1ps
module test_ipfb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [2:0] lv [12];
  logic [11:0] src_enable;
  int err_count = 0;
  int tests_run = 0;
  logic [3:0] offs [4] = '{4'h0, 4'h2, 4'h3, 4'h4};
  logic [15:0] masks [4] = '{16'h7770, 16'h7777, 16'h0077, 16'h7770};
  logic [15:0] rstv [4] = '{ipfb_pkg::RST_BANK_FIVE, ipfb_pkg::RST_BANK_SEVEN,
    ipfb_pkg::RST_BANK_EIGHT, ipfb_pkg::RST_BANK_NINE};
  // Distinct codes per field within each register so that a swapped field shows up
  logic [15:0] mixv [4] = '{16'h1230, 16'h4567, 16'h0012, 16'h3450};
  logic [2:0] mixl [12] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3,
    3'h4, 3'h5};

  // Design, levels in source enable order
  ipfb_top u_ipfb_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_four_level(lv[0]), .compare_ch4_level(lv[1]),
    .compare_ch3_level(lv[2]), .uart_b_transmit_level(lv[3]), .uart_b_receive_level(lv[4]),
    .ext_irq_two_level(lv[5]), .timer_five_level(lv[6]), .spi_b_event_level(lv[7]),
    .spi_b_fault_level(lv[8]), .capture_ch5_level(lv[9]), .capture_ch4_level(lv[10]),
    .capture_ch3_level(lv[11]), .src_enable(src_enable));

  // Clock of 8 ns
  always #4 clk = ~clk;

  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe, data checked in the following cycle
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask

  // All levels and enables against one code
  task automatic chk_lv(input logic [2:0] e);
    for (int i = 0; i < 12; i++) begin
      chk("level", {13'h0, e}, {13'h0, lv[i]});
      chk("enable", {15'h0, |e}, {15'h0, src_enable[i]});
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 4; i++) rd_reg(offs[i], rstv[i]);
    $display("Test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(offs[i], 16'hffff);
      rd_reg(offs[i], masks[i]);
    end
    wr_reg(4'h1, 16'h0000);
    rd_reg(4'h1, 16'h0000);
    rd_reg(offs[0], masks[0]);
    $display("Test masks and unmapped done");
    for (int l = 0; l < 8; l++) begin
      for (int i = 0; i < 4; i++) wr_reg(offs[i], {4{1'b0, l[2:0]}} & masks[i]);
      repeat (2) @(posedge clk);
      #1;
      chk_lv(l[2:0]);
    end
    $display("Test level codes done");
    for (int i = 0; i < 4; i++) wr_reg(offs[i], mixv[i]);
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < 12; i++) chk("field", {13'h0, mixl[i]}, {13'h0, lv[i]});
    $display("Test field placement done");
    // Reset in mid-run must bring written registers back to level 4
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 4; i++) rd_reg(offs[i], rstv[i]);
    chk_lv(3'h4);
    $display("Test mid-run reset done");
    wrap_up();
  end
endmodule
